// ===== rtl/uart_bridge.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module uart_bridge
  import uart_bridge_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic ri_pin,
  input wire logic dcd_pin,
  output logic dtr_pin,
  output logic rts_pin,
  input wire logic infrared_mode_strap_n,
  input wire logic assist_rs232_strap,
  input wire logic suspend_inhibit_n,
  output logic usb_configured_n,
  output logic clock_out_true,
  output logic clock_out_complement,
  output logic rx_pull_up,
  output logic rx_pull_down,
  output logic suspend_enable
);

  function automatic logic par_calc(input logic [8:0] d, input logic nine,
                                    input logic [1:0] mode);
    logic p;
    p = nine ? ^d : ^d[7:0];
    case (mode)
      PAR_ODD: par_calc = ~p;
      PAR_EVEN: par_calc = p;
      PAR_MARK: par_calc = 1'b1;
      default: par_calc = 1'b0;
    endcase
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == REG_CTRL) || (a == REG_BAUD) || (a == REG_TXDATA) ||
                (a == REG_RXDATA) || (a == REG_STATUS);
  endfunction

  // ********************************
  // pin synchronisers
  // ********************************
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] pins_in;
  assign pins_in = {suspend_inhibit_n, assist_rs232_strap,
                    infrared_mode_strap_n, dcd_pin, ri_pin, dsr_pin,
                    cts_pin, rxd_pin};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 8'hFF;
      sync2_q <= 8'hFF;
    end
    else if (clk_en)
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // ********************************
  // strap capture
  // ********************************
  logic [1:0] strap_wait_q;
  logic strap_done_q;
  logic ir_q;
  logic assist_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      ir_q <= 1'b0;
      assist_q <= 1'b0;
    end
    else if (clk_en && !strap_done_q)
    begin
      if (strap_wait_q == STRAP_WAIT)
      begin
        ir_q <= ~sync2_q[5];
        assist_q <= sync2_q[6];
        strap_done_q <= 1'b1;
      end
      else
        strap_wait_q <= strap_wait_q + 2'h1;
    end
  end

  // ********************************
  // register bus
  // ********************************
  logic [7:0] ctrl_q;
  logic [23:0] div_q;
  logic [8:0] tx_buf_q;
  logic tx_full_q;
  logic [11:0] rx_word_q;
  logic rx_valid_q;
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic do_write;
  logic rx_read;
  logic tx_load;
  logic [3:0] modem_in;
  frame_t tx_state_q;

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rx_read = s_axi_arvalid && s_axi_arready &&
                   (s_axi_araddr == REG_RXDATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control, divisor and transmit buffer writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RESET;
      div_q <= DIV_RESET;
      tx_buf_q <= 9'h000;
      tx_full_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (do_write && aw_addr_q == REG_CTRL && w_strb_q[0])
        ctrl_q <= w_data_q[7:0];
      if (do_write && aw_addr_q == REG_BAUD && w_strb_q[2:0] == 3'h7)
        div_q <= (w_data_q[23:0] < DIV_MIN) ? DIV_MIN : w_data_q[23:0];
      if (tx_load)
        tx_full_q <= 1'b0;
      else if (do_write && aw_addr_q == REG_TXDATA && w_strb_q[0] &&
               !tx_full_q)
      begin
        tx_buf_q <= w_data_q[8:0];
        tx_full_q <= 1'b1;
      end
    end
  end

  // read port
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_q};
          REG_BAUD: s_axi_rdata <= {8'h00, div_q};
          REG_TXDATA: s_axi_rdata <= {23'h00_0000, tx_buf_q};
          REG_RXDATA: s_axi_rdata <= {20'h0_0000, rx_word_q};
          REG_STATUS: s_axi_rdata <= {22'h00_0000, sync2_q[7], assist_q,
                                      ir_q, modem_in, rx_valid_q,
                                      tx_state_q != FR_IDLE, tx_full_q};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ********************************
  // transmitter
  // ********************************
  logic [23:0] tx_cnt_q;
  logic [8:0] tx_shift_q;
  logic [3:0] tx_idx_q;
  logic tx_bit_q;
  logic [23:0] sir_thr_q;
  logic [3:0] last_idx;
  logic tx_par_q;

  assign tx_load = (tx_state_q == FR_IDLE) && tx_full_q;
  assign last_idx = ctrl_q[CTRL_NINE] ? 4'h8 : 4'h7;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_q <= FR_IDLE;
      tx_cnt_q <= 24'h00_0000;
      tx_shift_q <= 9'h000;
      tx_idx_q <= 4'h0;
      tx_bit_q <= 1'b1;
      tx_par_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tx_state_q == FR_IDLE)
      begin
        tx_bit_q <= 1'b1;
        if (tx_load)
        begin
          tx_state_q <= FR_START;
          tx_shift_q <= tx_buf_q;
          tx_cnt_q <= div_q - 24'h00_0001;
          tx_bit_q <= 1'b0;
          tx_par_q <= par_calc(tx_buf_q, ctrl_q[CTRL_NINE], ctrl_q[1:0]);
        end
      end
      else if (tx_cnt_q != 24'h00_0000)
        tx_cnt_q <= tx_cnt_q - 24'h00_0001;
      else
      begin
        tx_cnt_q <= div_q - 24'h00_0001;
        case (tx_state_q)
          FR_START:
          begin
            tx_state_q <= FR_DATA;
            tx_bit_q <= tx_shift_q[0];
            tx_idx_q <= 4'h0;
          end
          FR_DATA:
          begin
            if (tx_idx_q == last_idx)
            begin
              tx_state_q <= ctrl_q[CTRL_PAR_EN] ? FR_PAR : FR_STOP;
              tx_bit_q <= ctrl_q[CTRL_PAR_EN] ? tx_par_q : 1'b1;
            end
            else
            begin
              tx_idx_q <= tx_idx_q + 4'h1;
              tx_shift_q <= {1'b0, tx_shift_q[8:1]};
              tx_bit_q <= tx_shift_q[1];
            end
          end
          FR_PAR:
          begin
            tx_state_q <= FR_STOP;
            tx_bit_q <= 1'b1;
          end
          FR_STOP: tx_state_q <= FR_IDLE;
          default: tx_state_q <= FR_IDLE;
        endcase
      end
    end
  end

  // line driver
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sir_thr_q <= 24'h00_0000;
      txd_pin <= 1'b1;
    end
    else if (clk_en)
    begin
      sir_thr_q <= div_q - 24'((27'(div_q) * 27'(SIR_NUM)) >> SIR_SHIFT);
      txd_pin <= ir_q ? (!tx_bit_q && tx_cnt_q >= sir_thr_q) : tx_bit_q;
    end
  end

  // ********************************
  // receiver
  // ********************************
  frame_t rx_state_q;
  logic [23:0] rx_cnt_q;
  logic [23:0] rx_str_q;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_idx_q;
  logic rx_par_q;
  logic rx_lvl;
  logic [8:0] rx_data;

  assign rx_lvl = ir_q ? !(sync2_q[0] || rx_str_q != 24'h00_0000) :
                  (assist_q ? !sync2_q[0] : sync2_q[0]);
  assign rx_data = ctrl_q[CTRL_NINE] ? rx_shift_q : {1'b0, rx_shift_q[8:1]};

  // stretches a SIR pulse across the mid-bit sample point
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_str_q <= 24'h00_0000;
    else if (clk_en)
    begin
      if (ir_q && sync2_q[0])
        rx_str_q <= div_q - {2'h0, div_q[23:2]};
      else if (rx_str_q != 24'h00_0000)
        rx_str_q <= rx_str_q - 24'h00_0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_q <= FR_IDLE;
      rx_cnt_q <= 24'h00_0000;
      rx_shift_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_par_q <= 1'b0;
      rx_word_q <= 12'h000;
      rx_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rx_read)
        rx_valid_q <= 1'b0;
      if (rx_state_q == FR_IDLE)
      begin
        if (strap_done_q && !rx_lvl)
        begin
          rx_state_q <= FR_START;
          rx_cnt_q <= {1'b0, div_q[23:1]};
        end
      end
      else if (rx_cnt_q != 24'h00_0000)
        rx_cnt_q <= rx_cnt_q - 24'h00_0001;
      else
      begin
        rx_cnt_q <= div_q - 24'h00_0001;
        case (rx_state_q)
          FR_START:
          begin
            rx_state_q <= rx_lvl ? FR_IDLE : FR_DATA;
            rx_idx_q <= 4'h0;
          end
          FR_DATA:
          begin
            rx_shift_q <= {rx_lvl, rx_shift_q[8:1]};
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == last_idx)
              rx_state_q <= ctrl_q[CTRL_PAR_EN] ? FR_PAR : FR_STOP;
          end
          FR_PAR:
          begin
            rx_par_q <= rx_lvl;
            rx_state_q <= FR_STOP;
          end
          FR_STOP:
          begin
            rx_state_q <= FR_IDLE;
            rx_word_q <= {rx_valid_q && !rx_read, !rx_lvl,
                          ctrl_q[CTRL_PAR_EN] && (rx_par_q != par_calc(
                            rx_data, ctrl_q[CTRL_NINE], ctrl_q[1:0])),
                          rx_data};
            rx_valid_q <= 1'b1;
          end
          default: rx_state_q <= FR_IDLE;
        endcase
      end
    end
  end

  // ********************************
  // modem, assist and power pins
  // ********************************
  logic [7:0] cko_cnt_q;
  logic cko_q;

  assign modem_in = ir_q ? sync2_q[4:1] : ~sync2_q[4:1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cko_cnt_q <= 8'h00;
      cko_q <= 1'b0;
    end
    else if (clk_en && assist_q)
    begin
      if (cko_cnt_q == CKO_HALF - 8'h01)
      begin
        cko_cnt_q <= 8'h00;
        cko_q <= ~cko_q;
      end
      else
        cko_cnt_q <= cko_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dtr_pin <= 1'b1;
      rts_pin <= 1'b1;
      usb_configured_n <= 1'b1;
      clock_out_true <= 1'b0;
      clock_out_complement <= 1'b0;
      rx_pull_up <= 1'b0;
      rx_pull_down <= 1'b0;
      suspend_enable <= 1'b1;
    end
    else if (clk_en)
    begin
      dtr_pin <= ir_q ? ctrl_q[CTRL_DTR] : !ctrl_q[CTRL_DTR];
      rts_pin <= ir_q ? ctrl_q[CTRL_RTS] : !ctrl_q[CTRL_RTS];
      usb_configured_n <= assist_q || !ctrl_q[CTRL_CONF];
      clock_out_true <= assist_q && cko_q;
      clock_out_complement <= assist_q && !cko_q;
      rx_pull_up <= ctrl_q[CTRL_PULL] && strap_done_q && !(ir_q || assist_q);
      rx_pull_down <= ctrl_q[CTRL_PULL] && strap_done_q && (ir_q || assist_q);
      suspend_enable <= sync2_q[7];
    end
  end

endmodule // uart_bridge

// ===== rtl/uart_bridge_pkg.sv
package uart_bridge_pkg;

  // ********************************
  // clock and bit timing
  // ********************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_RESET = 115_200;
  localparam logic [23:0] DIV_RESET = 24'(CLK_HZ / BAUD_RESET);
  localparam logic [23:0] DIV_MIN = 24'h00_0010;
  localparam int unsigned CKO_HZ = 12_000_000;
  localparam logic [7:0] CKO_HALF = 8'(CLK_HZ / (2 * CKO_HZ));
  localparam int unsigned SIR_NUM = 3;
  localparam int unsigned SIR_SHIFT = 4;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // ********************************
  // register map
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int unsigned CTRL_PAR_LO = 0;
  localparam int unsigned CTRL_PAR_EN = 2;
  localparam int unsigned CTRL_NINE = 3;
  localparam int unsigned CTRL_DTR = 4;
  localparam int unsigned CTRL_RTS = 5;
  localparam int unsigned CTRL_CONF = 6;
  localparam int unsigned CTRL_PULL = 7;
  localparam logic [7:0] CTRL_RESET = 8'h80;

  localparam int unsigned RX_PERR = 9;
  localparam int unsigned RX_FERR = 10;
  localparam int unsigned RX_OVR = 11;

  localparam int unsigned ST_TX_FULL = 0;
  localparam int unsigned ST_TX_BUSY = 1;
  localparam int unsigned ST_RX_VALID = 2;
  localparam int unsigned ST_MODEM_LO = 3;
  localparam int unsigned ST_IR = 7;
  localparam int unsigned ST_ASSIST = 8;
  localparam int unsigned ST_NOSUSP = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAR_ODD = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_MARK = 2'b10,
    PAR_SPACE = 2'b11
  } parity_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_START = 3'b001,
    FR_DATA = 3'b010,
    FR_PAR = 3'b011,
    FR_STOP = 3'b100
  } frame_t;

endpackage

// ===== dv/uart_bridge_props.sv
`timescale 1ns/1ns
module uart_bridge_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd_pin,
  input wire logic suspend_inhibit_n,
  input wire logic suspend_enable,
  input wire logic usb_configured_n,
  input wire logic clock_out_true,
  input wire logic clock_out_complement
);
  // ********
  // line timing helper
  // ********
  logic txd_prev_q;
  logic [7:0] run_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_prev_q <= 1'b1;
      run_q <= 8'hFF;
    end
    else
    begin
      txd_prev_q <= txd_pin;
      if (txd_pin != txd_prev_q)
        run_q <= 8'h00;
      else if (run_q != 8'hFF)
        run_q <= run_q + 8'h01;
    end
  end

  // ********
  // checks
  // ********
  a_aw_taken_drop: assert property (
    s_axi_awvalid && s_axi_awready && clk_en |=> !s_axi_awready)
    else $error("write address ready stayed high");
  a_b_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_tx_bit_len: assert property (
    txd_pin != txd_prev_q |-> run_q >= 8'h0F)
    else $error("serial bit too short");
  a_suspend_sync: assert property (
    (clk_en && $stable(suspend_inhibit_n)) [*6]
    |-> suspend_enable == suspend_inhibit_n)
    else $error("suspend enable wrong");
  a_clk_pair: assert property (
    clock_out_true || clock_out_complement
    |-> clock_out_true != clock_out_complement) else $error("clocks equal");
  a_clk_half: assert property (
    $changed(clock_out_true) |=> $stable(clock_out_true) [*8])
    else $error("clock half period short");
  a_cfg_mode: assert property (
    !usb_configured_n |-> !clock_out_true && !clock_out_complement)
    else $error("configured output in assist mode");

  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_clock: cover property ($rose(clock_out_true));
  c_tx: cover property ($fell(txd_pin));
endmodule // uart_bridge_props

bind uart_bridge uart_bridge_props u_props (.*);

// ===== dv/serial_peer.sv
`timescale 1ns/1ns
module serial_peer (
  input wire logic aclk,
  input wire logic txd_pin,
  input wire logic inv,
  input int baud,
  output logic rxd_pin,
  output logic got,
  output logic [10:0] got_bits
);
  // ********
  // serial line model
  // ********
  logic line_q = 1'b1;
  // level converter inverts in assist and infrared modes
  assign rxd_pin = line_q ^ inv;
  initial got = 1'b0;

  task automatic send(input logic [10:0] bits);
    for (int i = 0; i < 11; i++)
    begin
      line_q <= bits[i];
      repeat (baud) @(posedge aclk);
    end
    line_q <= 1'b1;
  endtask

  always
  begin
    @(negedge txd_pin);
    repeat (baud / 2) @(posedge aclk);
    for (int i = 0; i < 11; i++)
    begin
      got_bits[i] <= txd_pin;
      if (i < 10)
        repeat (baud) @(posedge aclk);
    end
    got <= 1'b1;
    @(posedge aclk);
    got <= 1'b0;
  end
endmodule // serial_peer

// ===== dv/usb_serial_bridge_uart_side_tb.sv
`timescale 1ns/1ns
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin failures++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (x)); end end
module usb_serial_bridge_uart_side_tb;
  import uart_bridge_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cts_pin = 1'b1, dsr_pin = 1'b1, ri_pin = 1'b1, dcd_pin = 1'b1;
  logic infrared_mode_strap_n = 1'b1, assist_rs232_strap = 1'b0;
  logic suspend_inhibit_n = 1'b1, inv = 1'b0;
  logic rxd_pin, txd_pin, dtr_pin, rts_pin, usb_configured_n, got, ck;
  logic clock_out_true, clock_out_complement, rx_pull_up, rx_pull_down;
  logic suspend_enable;
  logic [10:0] got_bits, f, fx;
  logic [65:0] e;
  logic [31:0] rng = 32'h0000_DAF1;
  logic [65:0] exp_q[$];
  logic [10:0] ser_q[$];
  int baud = 20, failures = 0, checks_done = 0;

  always #2 aclk = ~aclk;
  uart_bridge uut (.*);
  serial_peer peer (.*);

  // ********
  // helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [10:0] frame(input logic [8:0] d,
                                        input logic [2:0] m);
    logic p;
    p = m[1] ? ~m[0] : (^d[7:0]) ^ ~m[0];
    return m[2] ? {1'b1, d, 1'b0} : {1'b1, p, d[7:0], 1'b0};
  endfunction

  task automatic do_reset(input logic a, input logic ir);
    aresetn <= 1'b0;
    assist_rs232_strap <= a;
    infrared_mode_strap_n <= !ir;
    // idle line low at the pin in assist and infrared modes
    inv <= a || ir;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_q.push_back({32'h0, r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({m, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ********
  // result watcher
  // ********
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      e = exp_q.pop_front();
      `CHK(s_axi_bresp, e[33:32])
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = exp_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata & e[65:34]}, {e[33:32], e[31:0] & e[65:34]})
    end
    if (got)
    begin
      fx = ser_q.pop_front();
      `CHK(got_bits, fx)
    end
  end

  initial
  begin
    #100000;
    failures++;
    stop_test();
  end

  // ********
  // scenarios
  // ********
  initial
  begin
    do_reset(1'b0, 1'b0);
    assist_rs232_strap <= 1'b1;
    `CHK({txd_pin, rx_pull_up, rx_pull_down}, 3'b110)
    rd(REG_CTRL, 32'hFF, {24'h0, CTRL_RESET}, RESP_OKAY);
    rd(REG_BAUD, 32'hFF_FFFF, {8'h0, DIV_RESET}, RESP_OKAY);
    wr(8'h14, 32'h0, RESP_SLVERR);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    wr(REG_BAUD, 32'h5, RESP_OKAY);
    rd(REG_BAUD, 32'hFF_FFFF, {8'h0, DIV_MIN}, RESP_OKAY);
    wr(REG_BAUD, 32'(baud), RESP_OKAY);
    for (int k = 0; k < 5; k++)
    begin
      rng = xs(rng);
      wr(REG_CTRL, k == 4 ? 32'h88 : 32'h84 + k, RESP_OKAY);
      f = frame(rng[8:0], k == 4 ? 3'b100 : {1'b0, 2'(k)});
      ser_q.push_back(f);
      fork
        wr(REG_TXDATA, {23'h0, rng[8:0]}, RESP_OKAY);
        peer.send(f);
      join
      while (ser_q.size() != 0)
        @(posedge aclk);
      rd(REG_RXDATA, k == 4 ? 32'h7FF : 32'h6FF, {23'h0, rng[8:0]}, RESP_OKAY);
    end
    wr(REG_CTRL, 32'h85, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      rng = xs(rng);
      f = frame({1'b0, rng[7:0]}, 3'b001);
      f[9 + k] = ~f[9 + k];
      peer.send(f);
      repeat (baud) @(posedge aclk);
      rd(REG_RXDATA, 32'hEFF, {21'h0, k == 1, k == 0, 1'b0, rng[7:0]}, RESP_OKAY);
    end
    for (int j = 0; j < 2; j++)
    begin
      wr(REG_CTRL, j ? 32'h80 : 32'hF0, RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK({dtr_pin, rts_pin}, {2{j[0]}})
      `CHK(usb_configured_n, j[0])
    end
    for (int k = 0; k < 4; k++)
    begin
      rng = xs(rng);
      {dcd_pin, ri_pin, dsr_pin, cts_pin} <= rng[3:0];
      suspend_inhibit_n <= rng[4];
      repeat (8) @(posedge aclk);
      `CHK(suspend_enable, rng[4])
      rd(REG_STATUS, 32'h3F8, {22'h0, rng[4], 2'b00, ~rng[3:0], 3'h0}, RESP_OKAY);
    end
    do_reset(1'b1, 1'b0);
    rd(REG_STATUS, 32'h180, 32'h100, RESP_OKAY);
    `CHK({rx_pull_up, rx_pull_down}, 2'b01)
    ck = clock_out_true;
    repeat (10) @(posedge aclk);
    `CHK(clock_out_true, ~ck)
    wr(REG_BAUD, 32'(baud), RESP_OKAY);
    wr(REG_CTRL, 32'hC5, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(usb_configured_n, 1'b1)
    rng = xs(rng);
    f = frame({1'b0, rng[7:0]}, 3'b001);
    peer.send(f);
    repeat (baud) @(posedge aclk);
    rd(REG_RXDATA, 32'hEFF, {24'h0, rng[7:0]}, RESP_OKAY);
    do_reset(1'b0, 1'b1);
    rd(REG_STATUS, 32'h180, 32'h080, RESP_OKAY);
    wr(REG_CTRL, 32'hB0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(txd_pin, 1'b0)
    `CHK({dtr_pin, rts_pin}, 2'b11)
    `CHK({rx_pull_up, rx_pull_down}, 2'b01)
    clk_en <= 1'b0;
    suspend_inhibit_n <= ~suspend_enable;
    repeat (8) @(posedge aclk);
    `CHK(suspend_enable, ~suspend_inhibit_n)
    clk_en <= 1'b1;
    stop_test();
  end
endmodule // usb_serial_bridge_uart_side_tb
